// ### core/stepper_cmd_pkg.sv
// constants and types shared by the stepper command decoder
package stepper_cmd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PARAM_W = 24;
  localparam int PARAM_DEPTH = 8;
  localparam int SPEED_W = 13;

  // register byte offsets
  localparam logic [7:0] OFS_CMD   = 8'h00;
  localparam logic [7:0] OFS_DLO   = 8'h04;
  localparam logic [7:0] OFS_DMID  = 8'h08;
  localparam logic [7:0] OFS_DHI   = 8'h0c;
  localparam logic [7:0] OFS_RDBK  = 8'h10;
  localparam logic [7:0] OFS_PSTAT = 8'h14;
  localparam logic [7:0] OFS_EVT   = 8'h18;
  localparam logic [7:0] OFS_MASK  = 8'h1c;
  localparam logic [7:0] OFS_MODE  = 8'h20;
  localparam logic [7:0] OFS_SPEED = 8'h24;

  // command byte opcode in bits 7:6
  localparam logic [1:0] OPC_OPER  = 2'h0;
  localparam logic [1:0] OPC_START = 2'h1;
  localparam logic [1:0] OPC_SEL   = 2'h2;
  localparam logic [1:0] OPC_OUT   = 2'h3;

  // operation command bits
  localparam int OP_START_BIT    = 0;
  localparam int OP_START_GO_BIT = 1;
  localparam int OP_STOP_BIT     = 2;
  // start mode command bits
  localparam int SM_ORIGIN_BIT = 0;
  localparam int SM_PRESET_BIT = 2;
  localparam int SM_DIR_BIT    = 3;
  // register select command bits
  localparam int SEL_FREEZE_BIT = 3;
  localparam int SEL_RAMP_BIT   = 4;
  localparam int SEL_GO_BIT     = 5;
  // output mode command bits
  localparam int OM_POS_BIT   = 0;
  localparam int OM_INH_BIT   = 1;
  localparam int OM_MASK_BIT  = 2;
  localparam int OM_HOLD_BIT  = 3;
  localparam int OM_SLOW_BIT  = 4;
  localparam int OM_EXT_BIT   = 5;

  // parameter register indices
  localparam logic [2:0] REG_COUNT = 3'h0;
  localparam logic [2:0] REG_LOW   = 3'h1;
  localparam logic [2:0] REG_HIGH  = 3'h2;
  localparam logic [2:0] REG_RDP   = 3'h5;

  // event bits, input bit positions
  localparam int EVT_GO   = 0;
  localparam int EVT_RAMP = 1;
  localparam int EVT_STOP = 2;
  localparam int IN_END    = 0;
  localparam int IN_ORIGIN = 1;
  localparam int IN_HALT   = 2;
  localparam int IN_GO     = 3;

  localparam int DEGLITCH_CYCLES = 4;
  localparam logic [2:0] DEGLITCH_LAST = 3'(DEGLITCH_CYCLES - 1);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RUN_IDLE    = 2'b00,
    RUN_WAIT_GO = 2'b01,
    RUN_ACTIVE  = 2'b10
  } run_state_e;
endpackage

// ### core/param_store.sv
// parameter register store with registered read data
`timescale 1ns/1ps
module param_store #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rd;
  } store_s;

  store_s s_reg;
  store_s s_next;

  if (DEPTH != (1 << AW) || WIDTH < 1) begin : g_bad_shape
    $error("param_store: DEPTH must equal 2**AW and WIDTH be positive");
  end

  always_comb begin
    s_next = s_reg;
    if (wr_en) begin
      s_next.mem[wr_addr] = wr_data;
    end
    s_next.rd = s_reg.mem[rd_addr];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rd;
endmodule // param_store

// ### core/stepper_pulse_mode_cmd_decode.sv
// stepper command decoder: select and output mode commands, pulse engine, axi4-lite slave
// Notes on behaviour
// - go input while waiting raises attention
// - writing go enable zero clears it
// - attention is OR of three flags
// - select command picks register 0 to 7
// - select bit 3 freezes remaining count
// - select bit 4 enables ramp-down interrupt
// - output mode bit 0 sets pulse polarity
// - unused pulse line idles inactive level
// - inhibit: no pulses, phases, limit stops
// - inhibited preset run acts as timer
// - output mode bit 2 masks phases
// - output mode bit 3 holds speed
// - slow sensitivity drops pulses under 4
// - extended monitor widens readback
// - ramp flag when count below point
`timescale 1ns/1ps
module stepper_pulse_mode_cmd_decode
  import stepper_cmd_pkg::*;
(
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic                                awvalid,
  output logic                                     awready,
  input  wire logic [stepper_cmd_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                                wvalid,
  output logic                                     wready,
  input  wire logic [stepper_cmd_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                          wstrb,
  output logic                                     bvalid,
  input  wire logic                                bready,
  output logic [1:0]                               bresp,
  input  wire logic                                arvalid,
  output logic                                     arready,
  input  wire logic [stepper_cmd_pkg::ADDR_W-1:0]  araddr,
  output logic                                     rvalid,
  input  wire logic                                rready,
  output logic [stepper_cmd_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                               rresp,
  input  wire logic                                outside_go_input_n,
  input  wire logic                                outside_halt_input_n,
  input  wire logic                                origin_sensor_input_n,
  input  wire logic                                end_limit_input_n,
  output logic [1:0]                               step_pulse_output,
  output logic [3:0]                               excitation_phase_outputs,
  output logic                                     attention_n,
  output logic                                     irq
);
  import stepper_cmd_pkg::*;

  typedef struct packed {
    run_state_e          state;
    logic [3:0]          sync1;
    logic [3:0]          sync2;
    logic [3:0]          sync3;
    logic [3:0]          clean;
    logic [2:0]          filt;
    logic [2:0][2:0]     dg_cnt;
    logic                go_prev;
    logic [2:0]          sel;
    logic                cnt_freeze;
    logic                ramp_int_en;
    logic                go_int_en;
    logic [5:0]          om;
    logic                origin_stop;
    logic                preset_stop;
    logic                dir_neg;
    logic [7:0]          stage_mid;
    logic [7:0]          stage_hi;
    logic [SPEED_W-1:0]  fl;
    logic [SPEED_W-1:0]  fh;
    logic [15:0]         rdp;
    logic [23:0]         count;
    logic [SPEED_W-1:0]  speed;
    logic [15:0]         acc;
    logic [1:0]          phase_idx;
    logic                go_flag;
    logic                ramp_flag;
    logic                stop_flag;
    logic [2:0]          evt;
    logic [2:0]          mask;
    logic [1:0]          pulse_out;
    logic [3:0]          phase_out;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rd_busy;
    logic [ADDR_W-1:0]   raddr;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [DATA_W-1:0]   rdata;
  } core_s;

  core_s s_reg;
  core_s s_next;

  logic                wr_take;
  logic                ar_take;
  logic                cmd_wr;
  logic [7:0]          wb;
  logic                mem_we;
  logic [PARAM_W-1:0]  commit_val;
  logic [PARAM_W-1:0]  mem_rdata;
  logic                running;
  logic                step;
  logic [16:0]         acc_sum;
  logic                go_set;
  logic                ramp_set;
  logic                stop_set;
  logic                ext_stop;
  logic                pulse_act;
  logic                pulse_lvl;
  logic                idle_lvl;

  // full-step two-phase excitation pattern
  function automatic logic [3:0] phase_pattern(input logic [1:0] idx);
    case (idx)
      2'h0:    phase_pattern = 4'h3;
      2'h1:    phase_pattern = 4'h6;
      2'h2:    phase_pattern = 4'hc;
      default: phase_pattern = 4'h9;
    endcase
  endfunction

  param_store #(.WIDTH(PARAM_W), .DEPTH(PARAM_DEPTH), .AW(3)) u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (mem_we),
    .wr_addr (s_reg.sel),
    .wr_data (commit_val),
    .rd_addr (s_reg.sel),
    .rd_data (mem_rdata)
  );

  // both write channels are taken together, so order between them never matters
  assign wr_take    = awvalid && wvalid && !s_reg.bvalid;
  assign ar_take    = arvalid && !s_reg.rd_busy && !s_reg.rvalid;
  assign wb         = wdata[7:0];
  assign cmd_wr     = wr_take && wstrb[0] && (awaddr == OFS_CMD);
  assign mem_we     = wr_take && wstrb[0] && (awaddr == OFS_DLO);
  assign commit_val = {s_reg.stage_hi, s_reg.stage_mid, wb};
  assign running    = (s_reg.state == RUN_ACTIVE);
  assign acc_sum    = {1'b0, s_reg.acc} + 17'(s_reg.speed);
  assign step       = running && acc_sum[16];

  always_comb begin
    s_next    = s_reg;
    go_set    = 1'b0;
    ramp_set  = 1'b0;
    stop_set  = 1'b0;
    ext_stop  = 1'b0;
    pulse_act = 1'b0;
    pulse_lvl = 1'b0;
    idle_lvl  = 1'b0;

    // three-stage pin synchronisers, accepted when stages two and three agree
    s_next.sync1 = {outside_go_input_n, outside_halt_input_n,
                    origin_sensor_input_n, end_limit_input_n};
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    for (int i = 0; i < 4; i++) begin
      if (s_reg.sync2[i] == s_reg.sync3[i]) begin
        s_next.clean[i] = s_reg.sync3[i];
      end
    end
    s_next.go_prev = s_reg.clean[IN_GO];

    for (int i = 0; i < 3; i++) begin
      if (!s_reg.om[OM_SLOW_BIT]) begin
        s_next.filt[i]   = s_reg.clean[i];
        s_next.dg_cnt[i] = '0;
      end else if (s_reg.clean[i] != s_reg.filt[i]) begin
        if (s_reg.dg_cnt[i] == DEGLITCH_LAST) begin
          s_next.filt[i]   = s_reg.clean[i];
          s_next.dg_cnt[i] = '0;
        end else begin
          s_next.dg_cnt[i] = s_reg.dg_cnt[i] + 3'h1;
        end
      end else begin
        s_next.dg_cnt[i] = '0;
      end
    end

    // pulse engine: phase accumulator, one step per carry
    s_next.acc = running ? acc_sum[15:0] : 16'h0000;
    if (step) begin
      if (!s_reg.cnt_freeze && s_reg.count != 24'h000000) begin
        s_next.count = s_reg.count - 24'h000001;
      end
      if (!s_reg.om[OM_INH_BIT]) begin
        s_next.phase_idx = s_reg.dir_neg ? s_reg.phase_idx - 2'h1
                                         : s_reg.phase_idx + 2'h1;
      end
      if (!s_reg.om[OM_HOLD_BIT]) begin
        if (s_reg.preset_stop && s_reg.count < {8'h00, s_reg.rdp}) begin
          if (s_reg.speed > s_reg.fl) begin
            s_next.speed = s_reg.speed - 13'h0001;
          end
        end else if (s_reg.speed < s_reg.fh) begin
          s_next.speed = s_reg.speed + 13'h0001;
        end
      end
    end

    // limit and origin stops are ignored while pulses are inhibited
    if (s_reg.state != RUN_IDLE) begin
      ext_stop = !s_reg.filt[IN_HALT]
              || (!s_reg.om[OM_INH_BIT] && !s_reg.filt[IN_END])
              || (!s_reg.om[OM_INH_BIT] && s_reg.origin_stop
                  && !s_reg.filt[IN_ORIGIN]);
    end
    case (s_reg.state)
      RUN_WAIT_GO: begin
        if (ext_stop) begin
          stop_set = 1'b1;
        end else if (s_reg.go_prev && !s_reg.clean[IN_GO]) begin
          s_next.state = RUN_ACTIVE;
          go_set       = s_reg.go_int_en;
        end
      end
      RUN_ACTIVE: begin
        // an inhibited preset run still counts, so the stop marks elapsed time
        if (ext_stop || (s_reg.preset_stop && s_reg.count == 24'h000000)) begin
          stop_set = 1'b1;
        end
      end
      default: begin
      end
    endcase
    if (stop_set) begin
      s_next.state = RUN_IDLE;
    end
    ramp_set = s_reg.ramp_int_en && running && !s_reg.ramp_flag
            && s_reg.count < {8'h00, s_reg.rdp};

    // host writes
    if (wr_take) begin
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      if (awaddr[1:0] != 2'h0 || awaddr > OFS_SPEED) begin
        s_next.bresp = RESP_SLVERR;
      end else if (!wstrb[0]) begin
        s_next.bresp = RESP_OKAY;
      end else if (awaddr == OFS_CMD) begin
        case (wb[7:6])
          OPC_SEL: begin
            s_next.sel         = wb[2:0];
            s_next.cnt_freeze  = wb[SEL_FREEZE_BIT];
            s_next.ramp_int_en = wb[SEL_RAMP_BIT];
            s_next.go_int_en   = wb[SEL_GO_BIT];
            if (!wb[SEL_RAMP_BIT]) begin
              s_next.ramp_flag = 1'b0;
            end
            if (!wb[SEL_GO_BIT]) begin
              s_next.go_flag = 1'b0;
            end
          end
          OPC_OUT: begin
            s_next.om = wb[5:0];
          end
          OPC_START: begin
            s_next.origin_stop = wb[SM_ORIGIN_BIT];
            s_next.preset_stop = wb[SM_PRESET_BIT];
            s_next.dir_neg     = wb[SM_DIR_BIT];
          end
          default: begin
            if (wb[OP_STOP_BIT]) begin
              if (s_reg.state != RUN_IDLE) begin
                stop_set = 1'b1;
              end
              s_next.state = RUN_IDLE;
            end else if (s_reg.state == RUN_IDLE
                         && (wb[OP_START_BIT] || wb[OP_START_GO_BIT])) begin
              s_next.state = wb[OP_START_GO_BIT] ? RUN_WAIT_GO : RUN_ACTIVE;
              s_next.speed = s_reg.fl;
              s_next.acc   = 16'h0000;
            end
          end
        endcase
      end else if (awaddr == OFS_DHI) begin
        s_next.stage_hi = wb;
      end else if (awaddr == OFS_DMID) begin
        s_next.stage_mid = wb;
      end else if (awaddr == OFS_DLO) begin
        // staged upper bytes take effect only with the low byte
        if (s_reg.sel == REG_COUNT) begin
          s_next.count = commit_val;
        end else if (s_reg.sel == REG_LOW) begin
          s_next.fl = commit_val[SPEED_W-1:0];
        end else if (s_reg.sel == REG_HIGH) begin
          s_next.fh = commit_val[SPEED_W-1:0];
        end else if (s_reg.sel == REG_RDP) begin
          s_next.rdp = commit_val[15:0];
        end
      end else if (awaddr == OFS_MASK) begin
        s_next.mask = wdata[2:0];
      end
    end else if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end

    // host reads: two cycles from address to data
    if (ar_take) begin
      s_next.rd_busy = 1'b1;
      s_next.raddr   = araddr;
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    s_next.stop_flag = s_reg.stop_flag;
    s_next.evt       = s_reg.evt;
    if (s_reg.rd_busy) begin
      s_next.rd_busy = 1'b0;
      s_next.rvalid  = 1'b1;
      s_next.rresp   = RESP_OKAY;
      s_next.rdata   = '0;
      if (s_reg.raddr[1:0] != 2'h0 || s_reg.raddr > OFS_SPEED) begin
        s_next.rresp = RESP_SLVERR;
      end else if (s_reg.raddr == OFS_RDBK) begin
        if (s_reg.sel == REG_COUNT) begin
          s_next.rdata = {8'h00, s_reg.count};
        end else if (s_reg.om[OM_EXT_BIT]) begin
          s_next.rdata = {8'h00, mem_rdata};
        end else begin
          s_next.rdata = {28'h0000000, s_reg.clean[IN_GO], s_reg.filt};
        end
      end else if (s_reg.raddr == OFS_PSTAT) begin
        s_next.rdata = {27'h0000000, s_reg.go_flag, s_reg.ramp_flag,
                        s_reg.stop_flag, s_reg.state};
        s_next.stop_flag = 1'b0;
      end else if (s_reg.raddr == OFS_EVT) begin
        s_next.rdata = {29'h00000000, s_reg.evt};
        s_next.evt   = 3'h0;
      end else if (s_reg.raddr == OFS_MASK) begin
        s_next.rdata = {29'h00000000, s_reg.mask};
      end else if (s_reg.raddr == OFS_MODE && s_reg.om[OM_EXT_BIT]) begin
        s_next.rdata = {17'h00000, s_reg.dir_neg, s_reg.preset_stop, s_reg.origin_stop,
                        s_reg.om, s_reg.go_int_en, s_reg.ramp_int_en,
                        s_reg.cnt_freeze, s_reg.sel};
      end else if (s_reg.raddr == OFS_SPEED && s_reg.om[OM_EXT_BIT]) begin
        s_next.rdata = {19'h00000, s_reg.speed};
      end
    end
    // hardware sets win over any clear in the same cycle
    if (go_set) begin
      s_next.go_flag = 1'b1;
    end
    if (ramp_set) begin
      s_next.ramp_flag = 1'b1;
    end
    if (stop_set) begin
      s_next.stop_flag = 1'b1;
    end
    s_next.evt = s_next.evt | {stop_set, ramp_set, go_set};

    // outputs
    pulse_act = running && !s_reg.om[OM_INH_BIT] && s_reg.acc[15];
    pulse_lvl = s_reg.om[OM_POS_BIT] ? pulse_act : !pulse_act;
    idle_lvl  = !s_reg.om[OM_POS_BIT];
    s_next.pulse_out = s_reg.dir_neg ? {idle_lvl, pulse_lvl}
                                     : {pulse_lvl, idle_lvl};
    s_next.phase_out = s_reg.om[OM_MASK_BIT] ? 4'h0
                                             : phase_pattern(s_reg.phase_idx);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg           <= '0;
      s_reg.sync1     <= 4'hf;
      s_reg.sync2     <= 4'hf;
      s_reg.sync3     <= 4'hf;
      s_reg.clean     <= 4'hf;
      s_reg.filt      <= 3'h7;
      s_reg.go_prev   <= 1'b1;
      s_reg.pulse_out <= 2'h3;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready                  = wr_take;
  assign wready                   = wr_take;
  assign arready                  = ar_take;
  assign bvalid                   = s_reg.bvalid;
  assign bresp                    = s_reg.bresp;
  assign rvalid                   = s_reg.rvalid;
  assign rresp                    = s_reg.rresp;
  assign rdata                    = s_reg.rdata;
  assign step_pulse_output        = s_reg.pulse_out;
  assign excitation_phase_outputs = s_reg.phase_out;
  assign attention_n = !(s_reg.go_flag || s_reg.ramp_flag || s_reg.stop_flag);
  assign irq                      = |(s_reg.evt & s_reg.mask);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_go_attention: assert property (
    s_reg.state == RUN_WAIT_GO && s_reg.go_int_en && !ext_stop
    && s_reg.go_prev && !s_reg.clean[IN_GO] |=> !attention_n)
    else $error("go request while waiting did not raise attention");
  a_go_clear: assert property (
    cmd_wr && wb[7:6] == OPC_SEL && !wb[SEL_GO_BIT] && !go_set |=> !s_reg.go_flag)
    else $error("go flag not cleared by enable write");
  a_attn_sources: assert property (
    go_set || ramp_set || stop_set |=> !attention_n)
    else $error("attention not raised by a new event");
  a_select_decode: assert property (
    cmd_wr && wb[7:6] == OPC_SEL |=> s_reg.sel == $past(wb[2:0]))
    else $error("register select not taken");
  a_count_freeze: assert property (
    s_reg.cnt_freeze && !mem_we |=> s_reg.count == $past(s_reg.count))
    else $error("frozen counter changed");
  a_pulse_idle: assert property (
    !s_reg.dir_neg ##1 !$past(s_reg.dir_neg)
    |-> step_pulse_output[0] == !$past(s_reg.om[OM_POS_BIT]))
    else $error("unused pulse line not idle");
  a_pulse_inhibit: assert property (
    s_reg.om[OM_INH_BIT] |=> step_pulse_output == {2{!$past(s_reg.om[OM_POS_BIT])}})
    else $error("pulse seen while inhibited");
  a_phase_mask: assert property (
    s_reg.om[OM_MASK_BIT] |=> excitation_phase_outputs == 4'h0)
    else $error("phases not masked");
  a_hold_speed: assert property (
    s_reg.om[OM_HOLD_BIT] && running && !wr_take |=> s_reg.speed == $past(s_reg.speed))
    else $error("speed moved while held");
  a_deglitch_width: assert property (
    s_reg.om[OM_SLOW_BIT] && $past(s_reg.om[OM_SLOW_BIT], 4) && $changed(s_reg.filt[IN_HALT])
    |-> $past(s_reg.clean[IN_HALT], 1) == $past(s_reg.clean[IN_HALT], 4))
    else $error("short input pulse passed the filter");
  a_ramp_flag: assert property (
    s_reg.ramp_int_en && running && s_reg.count < {8'h00, s_reg.rdp}
    && !(cmd_wr && wb[7:6] == OPC_SEL) |=> s_reg.ramp_flag)
    else $error("ramp-down flag missing");
endmodule // stepper_pulse_mode_cmd_decode

// ### dv/host_bus_model.sv
// axi4-lite host model that issues commands and parameter loads to the decoder
`timescale 1ns/1ps
module host_bus_model
  import stepper_cmd_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        awready,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  input  wire logic [31:0] rdata
);
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  int          n_to = 0;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready && wready) && i++ < 99);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge aclk); while (!bvalid && i++ < 199);
    bready <= 1'b0;
    if (!bvalid) n_to++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int i = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready && i++ < 99);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid && i++ < 199);
    d = rdata;
    rready <= 1'b0;
    if (!rvalid) n_to++;
  endtask

  // the low byte goes last because it commits the staged value
  task automatic load(input logic [2:0] r, input logic [23:0] v, input logic [7:0] f);
    wr(OFS_CMD, {24'h0, f | {5'h0, r}});
    wr(OFS_DHI, {24'h0, v[23:16]});
    wr(OFS_DMID, {24'h0, v[15:8]});
    wr(OFS_DLO, {24'h0, v[7:0]});
  endtask
endmodule // host_bus_model

// ### dv/stepper_pulse_mode_cmd_decode_tb.sv
// self-checking bench for the stepper command decoder
`timescale 1ns/1ps
module stepper_pulse_mode_cmd_decode_tb;
  import stepper_cmd_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic        attention_n, irq, go_n = 1'b1, halt_n = 1'b1, org_n = 1'b1, end_n = 1'b1;
  logic [31:0] rdata, rv;
  logic [23:0] cnt;
  logic [3:0]  ph, ph0;
  logic [1:0]  po, bresp, rresp;
  int          n_mismatch = 0, comparisons = 0;

  always #5 aclk = ~aclk;

  stepper_pulse_mode_cmd_decode DUT (.aclk, .aresetn, .awvalid(host.awvalid), .awready,
    .awaddr(host.awaddr), .wvalid(host.wvalid), .wready, .wdata(host.wdata),
    .wstrb(host.wstrb), .bvalid, .bready(host.bready), .bresp, .arvalid(host.arvalid),
    .arready, .araddr(host.araddr), .rvalid, .rready(host.rready), .rdata, .rresp,
    .outside_go_input_n(go_n), .outside_halt_input_n(halt_n), .origin_sensor_input_n(org_n),
    .end_limit_input_n(end_n), .step_pulse_output(po), .excitation_phase_outputs(ph),
    .attention_n, .irq);
  host_bus_model host (.aclk, .awready, .wready, .bvalid, .arready, .rvalid, .rdata);

  function automatic logic [1:0] idle_lvl(input logic pos);
    return pos ? 2'b00 : 2'b11;
  endfunction

  task automatic give_verdict;
    n_mismatch += host.n_to;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    host.rd(a, rv);
    chk(nm, e, rv);
  endtask
  task automatic wait_att(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && attention_n !== v; i++) @(posedge aclk);
    chk("attention", {31'h0, v}, {31'h0, attention_n});
    if (attention_n !== v) give_verdict();
  endtask
  task automatic cmd(input logic [7:0] c);
    host.wr(OFS_CMD, {24'h0, c});
  endtask
  task automatic halt(input int n);
    @(posedge aclk);
    halt_n <= 1'b0;
    repeat (n) @(posedge aclk);
    halt_n <= 1'b1;
  endtask

  always @(posedge aclk) begin
    if (host.n_to != 0) begin
      give_verdict();
    end
  end
  initial begin
    repeat (100000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    void'($urandom(94));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("attention", 1, attention_n);
    chk("idle", idle_lvl(0), po);
    chk("phases", 4'h3, ph);
    cmd(8'he0);
    for (int r = 1; r < 8; r++) begin
      cnt = 24'($urandom);
      host.load(3'(r), cnt, 8'h80);
      chk("bresp", RESP_OKAY, bresp);
      rchk("param", OFS_RDBK, {8'h0, cnt});
      chk("rresp", RESP_OKAY, rresp);
    end
    host.wr(OFS_DHI, 32'h5a);
    rchk("staged", OFS_RDBK, {8'h0, cnt});
    rchk("mode ext", OFS_MODE, 32'h807);
    cmd(8'hc5);
    rchk("mode std", OFS_MODE, 32'h0);
    chk("masked", 4'h0, ph);
    chk("idle pos", idle_lvl(1), po);
    host.load(3'h1, 24'h1000, 8'h80);
    host.load(3'h2, 24'h1800, 8'h80);
    cnt = 24'h800 + 24'($urandom % 256);
    host.load(3'h0, cnt, 8'h88);
    cmd(8'hc0);
    host.wr(OFS_MASK, 32'h4);
    cmd(8'h01);
    repeat (100) @(posedge aclk);
    rchk("frozen", OFS_RDBK, {8'h0, cnt});
    halt(10);
    wait_att(0, 50);
    chk("irq", 1, irq);
    rchk("event", OFS_EVT, 32'h4);
    chk("irq", 0, irq);
    rchk("status", OFS_PSTAT, 32'h4);
    wait_att(1, 4);
    cmd(8'h80);
    cmd(8'h01);
    repeat (100) @(posedge aclk);
    host.rd(OFS_RDBK, rv);
    chk("counting", 1, rv < {8'h0, cnt});
    cmd(8'h04);
    rchk("status", OFS_PSTAT, 32'h4);
    cmd(8'ha0);
    cmd(8'h02);
    go_n <= 1'b0;
    wait_att(0, 40);
    rchk("status", OFS_PSTAT, 32'h12);
    cmd(8'h80);
    wait_att(1, 4);
    go_n <= 1'b1;
    cmd(8'h04);
    host.rd(OFS_PSTAT, rv);
    host.load(3'h5, 24'h200, 8'h90);
    host.load(3'h0, 24'h100, 8'h90);
    cmd(8'h01);
    wait_att(0, 20);
    cmd(8'h80);
    wait_att(1, 4);
    cmd(8'hf8);
    host.rd(OFS_SPEED, rv);
    halt(2);
    repeat (20) @(posedge aclk);
    chk("short halt", 1, attention_n);
    rchk("held speed", OFS_SPEED, rv);
    halt(10);
    wait_att(0, 40);
    host.rd(OFS_PSTAT, rv);
    cmd(8'hc2);
    cmd(8'h4c);
    host.load(3'h0, 24'h5, 8'h80);
    end_n <= 1'b0;
    ph0 = ph;
    cmd(8'h01);
    repeat (40) begin
      @(posedge aclk);
      chk("inhibit", {ph0, idle_lvl(0), 1'b1}, {ph, po, attention_n});
    end
    wait_att(0, 400);
    give_verdict();
  end
endmodule // stepper_pulse_mode_cmd_decode_tb
